// ### src/btcce_pkg.sv
package btcce_pkg;
  // Operation codes handed over by the decoder, one-hot so that a stray code is easy to spot.
  typedef enum logic [6:0] {
    BTCCE_OP_NONE = 7'h00,
    BTCCE_OP_BIT_TEST_SKIP_IF_CLEAR = 7'h01,
    BTCCE_OP_BIT_TEST_SKIP_IF_SET = 7'h02,
    BTCCE_OP_INDIRECT_CALL_VIA_ACCUMULATOR = 7'h04,
    BTCCE_OP_CLEAR_ACCUMULATOR = 7'h08,
    BTCCE_OP_CLEAR_FILE_REGISTER = 7'h10,
    BTCCE_OP_COMPLEMENT_REGISTER = 7'h20
  } btcce_op_t;

  // Execution states.
  typedef enum logic [2:0] {
    BTCCE_ST_EXEC = 3'h1,
    BTCCE_ST_SKIP = 3'h2,
    BTCCE_ST_CALL2 = 3'h4
  } btcce_state_t;

  localparam int BTCCE_DATA_W = 8;
  localparam int BTCCE_PC_W = 11;
  localparam int BTCCE_ADDR_W = 7;
  localparam int BTCCE_SP_W = 3;
  localparam int BTCCE_PC_HI_LSB = 8;
  localparam int BTCCE_PC_HI_MSB = 10;
  localparam int BTCCE_TABLE_HIGH_POINTER_USED_MSB = 2;
  localparam logic [7:0] BTCCE_ZERO_BYTE = 8'h00;
  localparam logic [10:0] BTCCE_PC_STEP = 11'h001;
  localparam logic [2:0] BTCCE_SP_STEP = 3'h1;
  localparam logic [2:0] BTCCE_SP_RESET = 3'h0;
  localparam logic [10:0] BTCCE_PC_RESET = 11'h000;
  localparam logic BTCCE_DEST_ACC = 1'b0;
endpackage

// ### src/btcce_result_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Combinational data path: bit select, complement and zero detect.
module btcce_result_unit (
  // Operands.
  input wire logic [7:0] reg_value,
  input wire logic [2:0] bit_sel,
  // Results.
  output logic sel_bit,
  output logic [7:0] comp_value,
  output logic comp_zero
);
  // Selected bit and inverted operand.
  always_comb begin
    sel_bit = reg_value[bit_sel];
    comp_value = ~reg_value;
    comp_zero = (comp_value == btcce_pkg::BTCCE_ZERO_BYTE);
  end
endmodule
`default_nettype wire

// ### src/btcce_exec.sv
`timescale 1ns/1ps
`default_nettype none
module btcce_exec (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Decoded instruction from the fetch stage.
  input wire logic instr_valid,
  input wire btcce_pkg::btcce_op_t instr_op,
  input wire logic [6:0] instr_addr,
  input wire logic [2:0] instr_bit,
  input wire logic instr_dest,
  input wire logic [10:0] instr_pc,
  // Core state read by this block.
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] acc_value,
  input wire logic [7:0] table_high_pointer,
  // Fetch control.
  output logic busy,
  output logic discard_fetched,
  // File register write port.
  output logic [6:0] file_addr,
  output logic file_we,
  output logic [7:0] file_wdata,
  // Accumulator and zero flag.
  output logic acc_we,
  output logic [7:0] acc_wdata,
  output logic zero_we,
  output logic zero_wdata,
  // Program counter load.
  output logic pc_load,
  output logic [10:0] pc_target,
  // Return stack push.
  output logic stack_push,
  output logic [2:0] stack_ptr,
  output logic [10:0] stack_wdata
);
  // All registered state of the block.
  typedef struct packed {
    btcce_pkg::btcce_state_t state;
    logic file_we;
    logic [7:0] file_wdata;
    logic acc_we;
    logic [7:0] acc_wdata;
    logic zero_we;
    logic zero_wdata;
    logic pc_load;
    logic [10:0] pc_target;
    logic stack_push;
    logic [2:0] stack_ptr;
    logic [10:0] stack_wdata;
  } btcce_regs_t;

  // Reset image: executor ready, no strobe pending, stack pointer at its first entry.
  localparam btcce_regs_t BTCCE_REGS_RESET = '{
    state: btcce_pkg::BTCCE_ST_EXEC,
    file_we: 1'h0,
    file_wdata: btcce_pkg::BTCCE_ZERO_BYTE,
    acc_we: 1'h0,
    acc_wdata: btcce_pkg::BTCCE_ZERO_BYTE,
    zero_we: 1'h0,
    zero_wdata: 1'h0,
    pc_load: 1'h0,
    pc_target: btcce_pkg::BTCCE_PC_RESET,
    stack_push: 1'h0,
    stack_ptr: btcce_pkg::BTCCE_SP_RESET,
    stack_wdata: btcce_pkg::BTCCE_PC_RESET
  };

  // Every write strobe is a one-cycle pulse, while the data fields keep their last value.
  function automatic btcce_regs_t drop_strobes(input btcce_regs_t s);
    btcce_regs_t r;
    r = s;
    r.file_we = 1'h0;
    r.acc_we = 1'h0;
    r.zero_we = 1'h0;
    r.pc_load = 1'h0;
    r.stack_push = 1'h0;
    return r;
  endfunction

  // Skip decision shared by both bit tests; any other op code never skips.
  function automatic logic skip_wanted(input btcce_pkg::btcce_op_t op, input logic bit_value);
    logic want;
    want = 1'h0;
    // The two tests differ only in which bit value turns the next instruction into a NOP.
    if (op == btcce_pkg::BTCCE_OP_BIT_TEST_SKIP_IF_CLEAR) begin
      want = !bit_value;
    end else if (op == btcce_pkg::BTCCE_OP_BIT_TEST_SKIP_IF_SET) begin
      want = bit_value;
    end
    return want;
  endfunction

  btcce_regs_t st_reg;
  btcce_regs_t st_next;
  logic sel_bit;
  logic [7:0] comp_value;
  logic comp_zero;

  btcce_result_unit u_result (
    .reg_value(file_rdata),
    .bit_sel(instr_bit),
    .sel_bit(sel_bit),
    .comp_value(comp_value),
    .comp_zero(comp_zero)
  );

  // The address is combinational so the register file can return data in the same cycle.
  // Limitation: the write strobes come one cycle after the read, so the fetch stage must
  // hold the address through that cycle for the write to land in the same register.
  // Registering the address instead would cost a cycle on every read-modify-write op.
  assign file_addr = instr_addr;
  // A new instruction is only accepted in the execute state; others are stalled by fetch.
  assign busy = (st_reg.state != btcce_pkg::BTCCE_ST_EXEC);
  assign discard_fetched = (st_reg.state == btcce_pkg::BTCCE_ST_SKIP);
  assign file_we = st_reg.file_we;
  assign file_wdata = st_reg.file_wdata;
  assign acc_we = st_reg.acc_we;
  assign acc_wdata = st_reg.acc_wdata;
  assign zero_we = st_reg.zero_we;
  assign zero_wdata = st_reg.zero_wdata;
  assign pc_load = st_reg.pc_load;
  assign pc_target = st_reg.pc_target;
  assign stack_push = st_reg.stack_push;
  assign stack_ptr = st_reg.stack_ptr;
  assign stack_wdata = st_reg.stack_wdata;

  // Next-state logic; write strobes are single-cycle pulses, data holds until replaced.
  always_comb begin
    st_next = drop_strobes(st_reg);
    unique case (st_reg.state)
      btcce_pkg::BTCCE_ST_EXEC: begin
        if (instr_valid) begin
          unique case (instr_op)
            btcce_pkg::BTCCE_OP_BIT_TEST_SKIP_IF_CLEAR: begin
              // Flags are not touched by the tests.
              if (skip_wanted(instr_op, sel_bit)) begin
                st_next.state = btcce_pkg::BTCCE_ST_SKIP;
              end
            end
            btcce_pkg::BTCCE_OP_BIT_TEST_SKIP_IF_SET: begin
              if (skip_wanted(instr_op, sel_bit)) begin
                st_next.state = btcce_pkg::BTCCE_ST_SKIP;
              end
            end
            btcce_pkg::BTCCE_OP_INDIRECT_CALL_VIA_ACCUMULATOR: begin
              st_next.stack_push = 1'b1;
              st_next.stack_wdata = instr_pc + btcce_pkg::BTCCE_PC_STEP;
              st_next.pc_target = {table_high_pointer[btcce_pkg::BTCCE_TABLE_HIGH_POINTER_USED_MSB:0],
                                   acc_value};
              st_next.state = btcce_pkg::BTCCE_ST_CALL2;
            end
            btcce_pkg::BTCCE_OP_CLEAR_ACCUMULATOR: begin
              st_next.acc_we = 1'b1;
              st_next.acc_wdata = btcce_pkg::BTCCE_ZERO_BYTE;
              st_next.zero_we = 1'b1;
              st_next.zero_wdata = 1'b1;
            end
            btcce_pkg::BTCCE_OP_CLEAR_FILE_REGISTER: begin
              st_next.file_we = 1'b1;
              st_next.file_wdata = btcce_pkg::BTCCE_ZERO_BYTE;
              st_next.zero_we = 1'b1;
              st_next.zero_wdata = 1'b1;
            end
            btcce_pkg::BTCCE_OP_COMPLEMENT_REGISTER: begin
              if (instr_dest == btcce_pkg::BTCCE_DEST_ACC) begin
                st_next.acc_we = 1'b1;
                st_next.acc_wdata = comp_value;
              end else begin
                st_next.file_we = 1'b1;
                st_next.file_wdata = comp_value;
              end
              st_next.zero_we = 1'b1;
              st_next.zero_wdata = comp_zero;
            end
            default: begin
              // Opcodes outside this group are executed elsewhere in the core.
            end
          endcase
        end
      end
      btcce_pkg::BTCCE_ST_SKIP: begin
        // The discarded instruction occupies this cycle as a NOP.
        st_next.state = btcce_pkg::BTCCE_ST_EXEC;
      end
      btcce_pkg::BTCCE_ST_CALL2: begin
        // Second call cycle: jump, and the pointer moves past the pushed entry.
        st_next.pc_load = 1'b1;
        st_next.stack_ptr = st_reg.stack_ptr + btcce_pkg::BTCCE_SP_STEP;
        st_next.state = btcce_pkg::BTCCE_ST_EXEC;
      end
      default: begin
        // An illegal state code recovers to execute.
        st_next.state = btcce_pkg::BTCCE_ST_EXEC;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= BTCCE_REGS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

// ### verification/btcce_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Ties each executor pulse to the instruction taken one edge earlier; the call jump and pointer step come two edges after it.
module btcce_chk (
  // Clock, reset, decoded instruction and the core state read by the executor.
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic instr_dest,
  input wire btcce_pkg::btcce_op_t instr_op,
  input wire logic [2:0] instr_bit,
  input wire logic [10:0] instr_pc,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] acc_value,
  input wire logic [7:0] table_high_pointer,
  // Executor outputs.
  input wire logic busy,
  input wire logic discard_fetched,
  input wire logic file_we,
  input wire logic acc_we,
  input wire logic zero_we,
  input wire logic zero_wdata,
  input wire logic pc_load,
  input wire logic stack_push,
  input wire logic [7:0] file_wdata,
  input wire logic [7:0] acc_wdata,
  input wire logic [10:0] pc_target,
  input wire logic [10:0] stack_wdata,
  input wire logic [2:0] stack_ptr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // The op code is one-hot, so a bit of tk names the taken instruction; busy masks refusals.
  wire logic [6:0] tk = (instr_valid && !busy) ? instr_op : 7'h00;
  wire logic [7:0] inv = ~file_rdata;
  wire logic [10:0] tgt = {table_high_pointer[2:0], acc_value};
  wire logic bit_now = file_rdata[instr_bit];
  skip_clear_a: assert property (
    tk[0] && !bit_now |=> discard_fetched && busy)
    else $error("skip on clear bit missing");
  skip_set_a: assert property (
    tk[1] && bit_now |=> discard_fetched ##1 !busy)
    else $error("skip on set bit missing");
  call_push_a: assert property (
    tk[2] |=> stack_push && stack_wdata == $past(instr_pc) + 11'h001)
    else $error("return address wrong");
  call_target_a: assert property (
    tk[2] |=> ##1 pc_load && pc_target == $past(tgt, 2))
    else $error("call target wrong");
  clear_acc_a: assert property (
    tk[3] |=> acc_we && acc_wdata == 8'h00 && zero_we && zero_wdata)
    else $error("accumulator clear wrong");
  clear_reg_a: assert property (
    tk[4] |=> file_we && file_wdata == 8'h00 && zero_we && zero_wdata)
    else $error("register clear wrong");
  comp_dest_a: assert property (
    tk[5] |=> ($past(instr_dest) ? (file_we && !acc_we && file_wdata == $past(inv))
                                 : (acc_we && !file_we && acc_wdata == $past(inv))))
    else $error("complement write wrong");
  comp_zero_a: assert property (
    tk[5] |=> zero_we && zero_wdata == ($past(inv) == 8'h00))
    else $error("complement zero flag wrong");
  test_flags_a: assert property (
    tk[0] || tk[1] |=> !zero_we && !acc_we && !file_we)
    else $error("bit test touched state");
  sp_step_a: assert property (
    tk[2] |=> $stable(stack_ptr) ##1 stack_ptr == $past(stack_ptr) + 3'h1)
    else $error("stack pointer step wrong");
  refused_op_a: assert property (
    instr_valid && busy |=> !acc_we && !file_we && !zero_we && !stack_push)
    else $error("refused instruction took effect");
  cover property (tk[2]);
  cover property (tk[0] && !bit_now);
  cover property (tk[5] && instr_dest);
  cover property (instr_valid && busy);
endmodule
`default_nettype wire

// ### verification/btcce_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
// Random instruction stream with a refused op parked on every busy cycle.
module btcce_exec_bench;
  logic clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, instr_dest = 1'b0;
  btcce_pkg::btcce_op_t instr_op = btcce_pkg::BTCCE_OP_NONE;
  logic [6:0] instr_addr = 7'h00, file_addr;
  logic [2:0] instr_bit = 3'h0, stack_ptr, sp = 3'h0;
  logic [10:0] instr_pc = 11'h000, pc_target, stack_wdata;
  logic [7:0] file_rdata = 8'h00, acc_value = 8'h00, table_high_pointer = 8'h00;
  logic [7:0] file_wdata, acc_wdata;
  logic busy, discard_fetched, file_we, acc_we, zero_we, zero_wdata, pc_load, stack_push;
  logic [15:0] lfsr = 16'h18A0;
  logic [32:0] e, m, g;
  logic [6:0] r_op;
  logic [7:0] r_dat;
  int err_count = 0, checks_done = 0, cycles = 0;
  btcce_exec DUT (
    .clk(clk), .rst(rst),
    .instr_valid(instr_valid), .instr_op(instr_op), .instr_addr(instr_addr),
    .instr_bit(instr_bit), .instr_dest(instr_dest), .instr_pc(instr_pc),
    .file_rdata(file_rdata), .acc_value(acc_value), .table_high_pointer(table_high_pointer),
    .busy(busy), .discard_fetched(discard_fetched),
    .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata),
    .acc_we(acc_we), .acc_wdata(acc_wdata), .zero_we(zero_we), .zero_wdata(zero_wdata),
    .pc_load(pc_load), .pc_target(pc_target),
    .stack_push(stack_push), .stack_ptr(stack_ptr), .stack_wdata(stack_wdata)
  );
  always #25 clk = ~clk;
  function automatic logic [15:0] lfsr_step(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Data fields only matter while their pulse is due, so the caller masks them.
  function automatic logic [32:0] expect_out(logic [6:0] op, logic [7:0] r, logic [2:0] b,
                                             logic d, logic [10:0] pc);
    logic [32:0] x;
    x = '0;
    case (op)
      7'h01: x[12] = !r[b];
      7'h02: x[12] = r[b];
      7'h04: x[11:0] = {1'b1, pc + 11'h001};
      7'h08: x[32] = 1'b1;
      7'h10: x[23] = 1'b1;
      7'h20: begin
        x[32:13] = {1'h1, ~r, 9'h000, 1'h1, r == 8'hFF};
        if (d) begin
          x[32:13] = {9'h000, 1'h1, ~r, 1'h1, r == 8'hFF};
        end
      end
      default: x = '0;
    endcase
    if (op[3] || op[4]) x[14:13] = 2'b11;
    return x;
  endfunction
  // An unknown result counts as a mismatch, never as a pass.
  task automatic check(logic ok, string msg);
    checks_done++;
    if (ok !== 1'h1) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic issue(logic [6:0] op, logic [7:0] r, logic [2:0] b, logic d);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op <= btcce_pkg::btcce_op_t'(op);
    instr_addr <= lfsr[6:0];
    instr_bit <= b;
    instr_dest <= d;
    file_rdata <= r;
    instr_pc <= lfsr[10:0];
    acc_value <= lfsr[15:8];
    table_high_pointer <= lfsr[7:0];
    e = expect_out(op, r, b, d, lfsr[10:0]);
    m = {1'b1, {8{e[32]}}, 1'b1, {8{e[23]}}, 1'b1, e[14], 2'b11, {11{e[11]}}};
    @(posedge clk);
    instr_valid <= e[12] || e[11];
    instr_op <= btcce_pkg::BTCCE_OP_CLEAR_ACCUMULATOR;
    #1;
    g = {acc_we, acc_wdata, file_we, file_wdata, zero_we, zero_wdata, discard_fetched,
         stack_push, stack_wdata};
    check((g & m) === e, "write strobes or data wrong");
    check(busy === (e[12] || e[11]) && pc_load === 1'h0, "busy or early jump wrong");
    check(stack_ptr === sp && file_addr === lfsr[6:0], "pointer or address wrong");
    if (e[12] || e[11]) begin
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      if (e[11]) begin
        sp = sp + 3'h1;
      end
      check(!acc_we && !busy && !discard_fetched, "refused op ran");
      check(pc_load === e[11] && stack_ptr === sp, "jump or pointer step wrong");
      check(!e[11] || pc_target === {lfsr[2:0], lfsr[15:8]}, "call target wrong");
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // A hang in the handshake ends the run as a failure.
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    issue(7'h20, 8'hFF, 3'h0, 1'b0);
    issue(7'h20, 8'hFF, 3'h0, 1'b1);
    issue(7'h01, 8'h7F, 3'h7, 1'b0);
    issue(7'h02, 8'h80, 3'h7, 1'b0);
    repeat (300) begin
      repeat (3) lfsr = lfsr_step(lfsr);
      r_op = 7'h01 << lfsr[14:12];
      r_dat = lfsr[7:0] ^ lfsr[15:8];
      issue(r_op, r_dat, lfsr[11:9], lfsr[3]);
    end
    // A second reset in mid-run must bring the stack pointer home and leave no jump or push strobe.
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    #1;
    sp = 3'h0;
    check(stack_ptr === 3'h0 && !busy && !pc_load && !stack_push, "reset state wrong");
    issue(7'h04, 8'h00, 3'h0, 1'h0);
    report_and_stop();
  end
endmodule
bind btcce_exec btcce_chk chk_i (
  .clk(clk), .rst(rst),
  .instr_valid(instr_valid), .instr_dest(instr_dest), .instr_op(instr_op),
  .instr_bit(instr_bit), .instr_pc(instr_pc), .file_rdata(file_rdata),
  .acc_value(acc_value), .table_high_pointer(table_high_pointer),
  .busy(busy), .discard_fetched(discard_fetched),
  .file_we(file_we), .acc_we(acc_we), .zero_we(zero_we), .zero_wdata(zero_wdata),
  .pc_load(pc_load), .stack_push(stack_push),
  .file_wdata(file_wdata), .acc_wdata(acc_wdata), .pc_target(pc_target),
  .stack_wdata(stack_wdata), .stack_ptr(stack_ptr)
);
`default_nettype wire
